// ==== design/cpecs_defines.svh ====
// Offsets, field positions, reset values and encodings of the error block
`ifndef CPECS_DEFINES_SVH
`define CPECS_DEFINES_SVH
// Cache index in every per-cache array
`define CPECS_DC 0
`define CPECS_IC 1
// Error-action field encodings
`define CPECS_EA_MCHK 2'h0
`define CPECS_EA_AUTO 2'h1
`define CPECS_EA_RST 2'h0
// Lock pattern marking a double-bit error
`define CPECS_LOCK_DBE 4'h6
// Register byte offsets
`define CPECS_ADR_DCCS 8'h00
`define CPECS_ADR_ICCS 8'h04
`define CPECS_ADR_DCADDR 8'h08
`define CPECS_ADR_ICADDR 8'h0c
`define CPECS_ADR_DCCNT 8'h10
`define CPECS_ADR_ICCNT 8'h14
`define CPECS_ADR_EVENT 8'h18
// Control and status field positions
`define CPECS_EA_LSB 0
`define CPECS_EA_MSB 1
`define CPECS_CS_LKSTEP 8
// Counter register halves
`define CPECS_CNT_LOC_LSB 0
`define CPECS_CNT_REM_LSB 16
`define CPECS_CNT_MAX 16'hffff
// Sticky event bits, one byte per cache
`define CPECS_ST_LTAG 0
`define CPECS_ST_LDATA 1
`define CPECS_ST_LPUSH 2
`define CPECS_ST_RTAG 3
`define CPECS_ST_RDATA 4
`define CPECS_ST_RPUSH 5
`define CPECS_ST_MCHK 6
`define CPECS_ST_STRIDE 8
`endif

// ==== design/cpecs_pkg.sv ====
// Types shared by the cache error cross-signaling block
package cpecs_pkg;
  // Local detection results from one cache array
  typedef struct packed {
    logic tag_perr;
    logic [3:0] tag_unc_way;
    logic [3:0] tag_cor_way;
    logic [3:0] drt_way;
    logic [3:0] lk_way;
    logic op_signal;
    logic cbi_op;
    logic hit;
    logic [3:0] hit_way;
    logic [3:0] data_perr_way;
    logic push_perr;
    logic push_pend;
    logic [31:0] addr;
  } cpecs_local_t;
  // Cross-signals sent to the partner
  typedef struct packed {
    logic tagerr;
    logic dataerr;
    logic pusherr;
    logic [3:0] tagway;
    logic [3:0] drtway;
    logic [3:0] lkway;
    logic [31:0] addr;
  } cpecs_xout_t;
  // Cross-signals received from the partner
  typedef struct packed {
    logic tagerr;
    logic dataerr;
    logic pusherr;
    logic [3:0] tagway;
    logic [3:0] drtway;
    logic [3:0] lkway;
  } cpecs_xin_t;
  // Actions requested from the cache and exception logic
  typedef struct packed {
    logic mchk;
    logic stall;
    logic [3:0] inval_way;
    logic [3:0] cor_way;
    logic [3:0] dirty_set_way;
    logic [3:0] lk_wr_way;
    logic [3:0] lk_wr_data;
    logic [3:0] reload_way;
  } cpecs_act_t;
  // Whole state of the top module
  typedef struct packed {
    logic [1:0][1:0] ea;
    logic lk_s1;
    logic lk_s2;
    cpecs_xin_t [1:0] xin_s1;
    cpecs_xin_t [1:0] xin_s2;
    cpecs_xout_t [1:0] xout;
    cpecs_act_t [1:0] act;
    logic [1:0][15:0] loc_cnt;
    logic [1:0][15:0] rem_cnt;
    logic [15:0] sticky;
    logic ack;
    logic [31:0] dat;
  } cpecs_state_t;
endpackage

// ==== design/cpecs_err_detect.sv ====
// Qualifies local parity errors of one cache into cross-signals and actions
`timescale 1ns/1ps
`include "cpecs_defines.svh"
module cpecs_err_detect #(
  parameter bit IS_DCACHE = 1'b1
) (
  // Cache array results and mode
  input wire cpecs_pkg::cpecs_local_t loc,
  input wire logic [1:0] mode,
  input wire logic lkstep,
  // Results
  output cpecs_pkg::cpecs_xout_t xout,
  output cpecs_pkg::cpecs_act_t act
);
  logic auto_m;
  logic tag_ev;
  logic data_ev;
  logic push_ev;

  // Only errors that lead to an operation or exception are reported
  always_comb begin
    auto_m = (mode == `CPECS_EA_AUTO);
    tag_ev = loc.tag_perr & loc.op_signal;
    data_ev = loc.hit & ~loc.tag_perr & loc.op_signal &
              (|(loc.hit_way & loc.data_perr_way));
    push_ev = IS_DCACHE & (loc.push_perr | loc.push_pend) &
              loc.op_signal;
  end

  // Outgoing cross-signals; correctable ways are never flagged
  always_comb begin
    xout.tagerr = tag_ev;
    xout.dataerr = data_ev;
    xout.pusherr = push_ev;
    xout.tagway = tag_ev ? loc.tag_unc_way : 4'h0;
    xout.drtway = (tag_ev && IS_DCACHE) ? loc.drt_way : 4'h0;
    xout.lkway = tag_ev ? loc.lk_way : 4'h0;
    xout.addr = loc.addr;
  end

  // Local handling; block invalidates raise no machine check on a tag error
  always_comb begin
    act.mchk = (~auto_m & tag_ev & ~loc.cbi_op) |
               (~auto_m & data_ev) | push_ev;
    act.stall = auto_m & tag_ev;
    act.inval_way = (auto_m && tag_ev) ? loc.tag_unc_way : 4'h0;
    act.cor_way = (auto_m && tag_ev) ?
                  (loc.tag_cor_way & ~loc.tag_unc_way) : 4'h0;
    act.dirty_set_way = (auto_m && tag_ev && IS_DCACHE) ?
                        (loc.drt_way & ~loc.tag_unc_way) : 4'h0;
    act.lk_wr_way = (auto_m && lkstep && tag_ev) ?
                    loc.lk_way : 4'h0;
    act.lk_wr_data = `CPECS_LOCK_DBE;
    act.reload_way = (auto_m && data_ev) ? loc.hit_way : 4'h0;
  end
endmodule

// ==== design/cpecs_xsig_in.sv ====
// Turns cross-signals from the partner into emulated error actions
`timescale 1ns/1ps
`include "cpecs_defines.svh"
module cpecs_xsig_in #(
  parameter bit IS_DCACHE = 1'b1
) (
  // Synchronised partner signals and mode
  input wire cpecs_pkg::cpecs_xin_t xin,
  input wire logic [1:0] mode,
  input wire logic lkstep,
  input wire logic [3:0] hit_way,
  // Emulated actions
  output cpecs_pkg::cpecs_act_t act
);
  logic auto_m;
  logic tg;
  logic dt;
  logic ps;

  // Nothing from the partner counts unless lockstep is on
  always_comb begin
    auto_m = (mode == `CPECS_EA_AUTO);
    tg = lkstep & xin.tagerr;
    dt = lkstep & xin.dataerr;
    ps = lkstep & xin.pusherr & IS_DCACHE;
  end

  // Tag ways win over dirty ways on the same way
  always_comb begin
    act.mchk = (~auto_m & (tg | dt)) | ps;
    act.stall = auto_m & tg;
    act.inval_way = (auto_m && tg) ? xin.tagway : 4'h0;
    act.cor_way = 4'h0;
    act.dirty_set_way = (auto_m && tg && IS_DCACHE) ?
                        (xin.drtway & ~xin.tagway) : 4'h0;
    act.lk_wr_way = tg ? xin.lkway : 4'h0;
    act.lk_wr_data = `CPECS_LOCK_DBE;
    act.reload_way = (auto_m && dt) ? hit_way : 4'h0;
  end
endmodule

// ==== design/cpecs_top.sv ====
// Cache parity error cross-signaling block with Wishbone registers
// Operation
// - Tag error pulse only when it causes action
// - Machine-check mode: tag error means machine check; code raises none when the tag error comes with a block invalidate (cbi_op)
// - Auto mode: extra cycle invalidates and corrects tags
// - Data error only on clean hit way
// - Push error on copyback parity error, signaled
// - Address valid only with tag or data strobe
// - Tag way output flags uncorrectable ways only
// - Dirty ways flagged; auto sets non-invalidated dirty
// - Auto with lockstep rewrites lock bits 0110
// - Machine-check mode leaves lock bits unchanged; code still drives lk_wr_way from incoming tag strobes under lockstep
// - All error outputs low during reset
// - Incoming signals used only under lockstep enable
// - Incoming data error: machine check or reload
// - Incoming push error raises machine check, may persist
// - Incoming tag strobe emulates errors on flagged ways
// - Auto: incoming strobe applies incoming dirty ways
// - Auto: invalidate every incoming tag-flagged way
// - Incoming dirty ways set dirty; tag wins
// - Incoming lock ways rewrite lock bits 0110
// - Lockstep off: ignore inputs, still drive outputs
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "cpecs_defines.svh"
module cpecs_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Lockstep enable pin
  input wire logic lkstep_en,
  // Local cache array results, index 0 data cache, 1 instruction cache
  input wire cpecs_pkg::cpecs_local_t [1:0] cache_local,
  // Cross-signals from the partner core
  input wire cpecs_pkg::cpecs_xin_t [1:0] xsig_in,
  // Cross-signals to the partner core and monitor
  output cpecs_pkg::cpecs_xout_t [1:0] xsig_out,
  // Actions to the cache arrays and exception logic
  output cpecs_pkg::cpecs_act_t [1:0] cache_act
);
  cpecs_pkg::cpecs_state_t st_ff;
  cpecs_pkg::cpecs_state_t nxt_st;
  cpecs_pkg::cpecs_xout_t [1:0] xout_c;
  cpecs_pkg::cpecs_act_t [1:0] lact_c;
  cpecs_pkg::cpecs_act_t [1:0] ract_c;
  logic [1:0] loc_ev;
  logic [1:0] rem_ev;
  logic [31:0] rd_data;
  logic bus_req;
  logic bus_wr;

  // One detector and one receiver per cache
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_cache
      cpecs_err_detect #(
        .IS_DCACHE(g == `CPECS_DC)
      ) u_det (
        .loc(cache_local[g]),
        .mode(st_ff.ea[g]),
        .lkstep(st_ff.lk_s2),
        .xout(xout_c[g]),
        .act(lact_c[g])
      );
      // Receiver sees only the second synchroniser stage
      cpecs_xsig_in #(
        .IS_DCACHE(g == `CPECS_DC)
      ) u_rx (
        .xin(st_ff.xin_s2[g]),
        .mode(st_ff.ea[g]),
        .lkstep(st_ff.lk_s2),
        .hit_way(cache_local[g].hit_way),
        .act(ract_c[g])
      );
      // Event flags feeding the event counters
      assign loc_ev[g] = xout_c[g].tagerr | xout_c[g].dataerr |
                         xout_c[g].pusherr;
      assign rem_ev[g] = st_ff.lk_s2 & (st_ff.xin_s2[g].tagerr |
                         st_ff.xin_s2[g].dataerr |
                         st_ff.xin_s2[g].pusherr);
    end
  endgenerate

  // Bus request qualifiers; a write commits on the acked edge only
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr = bus_req & wb_we_i & st_ff.ack;

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_data = 32'h0;
    if (wb_adr_i == `CPECS_ADR_DCCS) begin
      rd_data[`CPECS_EA_MSB:`CPECS_EA_LSB] = st_ff.ea[`CPECS_DC];
      rd_data[`CPECS_CS_LKSTEP] = st_ff.lk_s2;
    end else if (wb_adr_i == `CPECS_ADR_ICCS) begin
      rd_data[`CPECS_EA_MSB:`CPECS_EA_LSB] = st_ff.ea[`CPECS_IC];
      rd_data[`CPECS_CS_LKSTEP] = st_ff.lk_s2;
    end else if (wb_adr_i == `CPECS_ADR_DCADDR) begin
      rd_data = st_ff.xout[`CPECS_DC].addr;
    end else if (wb_adr_i == `CPECS_ADR_ICADDR) begin
      rd_data = st_ff.xout[`CPECS_IC].addr;
    end else if (wb_adr_i == `CPECS_ADR_DCCNT) begin
      rd_data[`CPECS_CNT_LOC_LSB +: 16] = st_ff.loc_cnt[`CPECS_DC];
      rd_data[`CPECS_CNT_REM_LSB +: 16] = st_ff.rem_cnt[`CPECS_DC];
    end else if (wb_adr_i == `CPECS_ADR_ICCNT) begin
      rd_data[`CPECS_CNT_LOC_LSB +: 16] = st_ff.loc_cnt[`CPECS_IC];
      rd_data[`CPECS_CNT_REM_LSB +: 16] = st_ff.rem_cnt[`CPECS_IC];
    end else if (wb_adr_i == `CPECS_ADR_EVENT) begin
      rd_data[15:0] = st_ff.sticky;
    end else begin
      rd_data = 32'h0;
    end
  end

  // Next state of the whole block
  always_comb begin
    nxt_st = st_ff;

    // Two-stage synchronisers for the partner pins and lockstep enable
    nxt_st.lk_s1 = lkstep_en;
    nxt_st.lk_s2 = st_ff.lk_s1;
    nxt_st.xin_s1 = xsig_in;
    nxt_st.xin_s2 = st_ff.xin_s1;

    for (int i = 0; i < 2; i++) begin
      // Outgoing signals; address only moves with a strobe
      nxt_st.xout[i] = xout_c[i];
      if (!(xout_c[i].tagerr || xout_c[i].dataerr)) begin
        nxt_st.xout[i].addr = st_ff.xout[i].addr;
      end

      // Local and emulated actions merge per way
      nxt_st.act[i].mchk = lact_c[i].mchk | ract_c[i].mchk;
      nxt_st.act[i].stall = lact_c[i].stall | ract_c[i].stall;
      nxt_st.act[i].inval_way = lact_c[i].inval_way |
                                ract_c[i].inval_way;
      nxt_st.act[i].cor_way = lact_c[i].cor_way & ~ract_c[i].inval_way;
      // Invalidation from either side beats a dirty set on that way
      nxt_st.act[i].dirty_set_way = (lact_c[i].dirty_set_way |
                                     ract_c[i].dirty_set_way) &
                                    ~(lact_c[i].inval_way |
                                      ract_c[i].inval_way);
      nxt_st.act[i].lk_wr_way = lact_c[i].lk_wr_way |
                                ract_c[i].lk_wr_way;
      nxt_st.act[i].lk_wr_data = `CPECS_LOCK_DBE;
      nxt_st.act[i].reload_way = lact_c[i].reload_way |
                                 ract_c[i].reload_way;

      // Saturating event counters
      if (loc_ev[i] && st_ff.loc_cnt[i] != `CPECS_CNT_MAX) begin
        nxt_st.loc_cnt[i] = st_ff.loc_cnt[i] + 16'h1;
      end
      if (rem_ev[i] && st_ff.rem_cnt[i] != `CPECS_CNT_MAX) begin
        nxt_st.rem_cnt[i] = st_ff.rem_cnt[i] + 16'h1;
      end
    end

    // Register writes, low byte lane for control, any lane clears counts
    if (bus_wr) begin
      if (wb_adr_i == `CPECS_ADR_DCCS) begin
        if (wb_sel_i[0]) begin
          nxt_st.ea[`CPECS_DC] = wb_dat_i[`CPECS_EA_MSB:`CPECS_EA_LSB];
        end
      end else if (wb_adr_i == `CPECS_ADR_ICCS) begin
        if (wb_sel_i[0]) begin
          nxt_st.ea[`CPECS_IC] = wb_dat_i[`CPECS_EA_MSB:`CPECS_EA_LSB];
        end
      end else if (wb_adr_i == `CPECS_ADR_DCCNT) begin
        if (|wb_sel_i) begin
          nxt_st.loc_cnt[`CPECS_DC] = {15'h0, loc_ev[`CPECS_DC]};
          nxt_st.rem_cnt[`CPECS_DC] = {15'h0, rem_ev[`CPECS_DC]};
        end
      end else if (wb_adr_i == `CPECS_ADR_ICCNT) begin
        if (|wb_sel_i) begin
          nxt_st.loc_cnt[`CPECS_IC] = {15'h0, loc_ev[`CPECS_IC]};
          nxt_st.rem_cnt[`CPECS_IC] = {15'h0, rem_ev[`CPECS_IC]};
        end
      end else if (wb_adr_i == `CPECS_ADR_EVENT) begin
        // Write one to clear, per byte lane
        if (wb_sel_i[0]) begin
          nxt_st.sticky[7:0] = st_ff.sticky[7:0] & ~wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          nxt_st.sticky[15:8] = st_ff.sticky[15:8] & ~wb_dat_i[15:8];
        end
      end
    end

    // Sticky events after the clear so a new event is never lost
    for (int i = 0; i < 2; i++) begin
      if (xout_c[i].tagerr) begin
        nxt_st.sticky[i * `CPECS_ST_STRIDE + `CPECS_ST_LTAG] = 1'b1;
      end
      if (xout_c[i].dataerr) begin
        nxt_st.sticky[i * `CPECS_ST_STRIDE + `CPECS_ST_LDATA] = 1'b1;
      end
      if (xout_c[i].pusherr) begin
        nxt_st.sticky[i * `CPECS_ST_STRIDE + `CPECS_ST_LPUSH] = 1'b1;
      end
      if (st_ff.lk_s2 && st_ff.xin_s2[i].tagerr) begin
        nxt_st.sticky[i * `CPECS_ST_STRIDE + `CPECS_ST_RTAG] = 1'b1;
      end
      if (st_ff.lk_s2 && st_ff.xin_s2[i].dataerr) begin
        nxt_st.sticky[i * `CPECS_ST_STRIDE + `CPECS_ST_RDATA] = 1'b1;
      end
      if (st_ff.lk_s2 && st_ff.xin_s2[i].pusherr) begin
        nxt_st.sticky[i * `CPECS_ST_STRIDE + `CPECS_ST_RPUSH] = 1'b1;
      end
      if (nxt_st.act[i].mchk) begin
        nxt_st.sticky[i * `CPECS_ST_STRIDE + `CPECS_ST_MCHK] = 1'b1;
      end
    end

    // Single-wait acknowledge; ack drops in the cycle after it is given
    nxt_st.ack = 1'b0;
    if (bus_req && !st_ff.ack) begin
      nxt_st.ack = 1'b1;
      nxt_st.dat = rd_data;
    end
  end

  // State register; everything clears to zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.ea[`CPECS_DC] <= `CPECS_EA_RST;
      st_ff.ea[`CPECS_IC] <= `CPECS_EA_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state register
  assign wb_dat_o = st_ff.dat;
  assign wb_ack_o = st_ff.ack;
  assign xsig_out = st_ff.xout;
  assign cache_act = st_ff.act;
endmodule

// ==== tb/cpecs_chk.sv ====
// Concurrent checks on the cache error cross-signaling block
`timescale 1ns/1ps
`include "cpecs_defines.svh"
module cpecs_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Lockstep and cache sides
  input wire logic lkstep_en,
  input wire cpecs_pkg::cpecs_local_t [1:0] cache_local,
  input wire cpecs_pkg::cpecs_xin_t [1:0] xsig_in,
  input wire cpecs_pkg::cpecs_xout_t [1:0] xsig_out,
  input wire cpecs_pkg::cpecs_act_t [1:0] cache_act
);
  cpecs_pkg::cpecs_local_t dl;
  cpecs_pkg::cpecs_xin_t di;
  cpecs_pkg::cpecs_xout_t dx;
  cpecs_pkg::cpecs_act_t da;
  logic [1:0] ea_ff;
  logic [2:0] lk_run_ff;
  logic auto_m;
  // Data cache views only; the instruction cache shares the same logic
  assign dl = cache_local[0];
  assign di = xsig_in[0];
  assign dx = xsig_out[0];
  assign da = cache_act[0];
  assign auto_m = (ea_ff == `CPECS_EA_AUTO);
  // Mode mirror and lockstep run length; the mode is not on a pin
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ea_ff <= 2'h0;
      lk_run_ff <= 3'h0;
    end else begin
      if (wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
          && wb_adr_i == `CPECS_ADR_DCCS) begin
        ea_ff <= wb_dat_i[1:0];
      end
      if (!lkstep_en) begin
        lk_run_ff <= 3'h0;
      end else if (lk_run_ff != 3'h7) begin
        lk_run_ff <= lk_run_ff + 3'h1;
      end
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Local tag event with no partner tag event landing in the same cycle
  sequence s_loc_tag;
    dl.tag_perr && dl.op_signal && !$past(di.tagerr, 2);
  endsequence
  sequence s_rem_tag;
    di.tagerr ##2 (auto_m && lk_run_ff > 3'h3 && !dl.tag_perr);
  endsequence
  property p_tag_out;
    !$past(rst) |-> dx.tagerr == $past(dl.tag_perr && dl.op_signal);
  endproperty
  a_tag_out: assert property (p_tag_out) else $error("tag strobe");
  property p_data_push;
    !$past(rst) |-> dx.dataerr == $past(dl.hit && !dl.tag_perr
      && dl.op_signal && |(dl.data_perr_way & dl.hit_way))
      && dx.pusherr == $past((dl.push_perr || dl.push_pend) && dl.op_signal);
  endproperty
  a_data_push: assert property (p_data_push)
    else $error("data or push");
  property p_tagway;
    dx.tagerr |-> dx.tagway == $past(dl.tag_unc_way)
      && dx.drtway == $past(dl.drt_way) && dx.lkway == $past(dl.lk_way);
  endproperty
  a_tagway: assert property (p_tagway) else $error("way flags");
  property p_addr;
    dx.tagerr || dx.dataerr |-> dx.addr == $past(dl.addr);
  endproperty
  a_addr: assert property (p_addr) else $error("error address");
  // A way flagged both ways is invalidated, so it is not also corrected
  property p_auto_tag;
    (auto_m and s_loc_tag) |=> da.stall
      && da.inval_way == $past(dl.tag_unc_way)
      && da.cor_way == $past(dl.tag_cor_way & ~dl.tag_unc_way)
      && da.dirty_set_way == $past(dl.drt_way & ~dl.tag_unc_way);
  endproperty
  a_auto_tag: assert property (p_auto_tag)
    else $error("auto cycle");
  property p_lock_auto;
    ((auto_m && lk_run_ff > 3'h3) and s_loc_tag) |=> da.lk_wr_way ==
      $past(dl.lk_way) && da.lk_wr_data == `CPECS_LOCK_DBE;
  endproperty
  a_lock_auto: assert property (p_lock_auto)
    else $error("lock rewrite");
  property p_mchk_tag;
    ((!auto_m && !dl.cbi_op) and s_loc_tag) |=> da.mchk
      && da.inval_way == 4'h0 && da.lk_wr_way == 4'h0;
  endproperty
  a_mchk_tag: assert property (p_mchk_tag)
    else $error("machine check");
  property p_remote_tag;
    s_rem_tag |=> da.stall && da.inval_way == $past(di.tagway, 3)
      && da.dirty_set_way == $past(di.drtway & ~di.tagway, 3)
      && da.lk_wr_way == $past(di.lkway, 3);
  endproperty
  a_remote_tag: assert property (p_remote_tag)
    else $error("remote tag");
  property p_push_rem;
    lkstep_en [*3] ##0 di.pusherr |-> ##3 da.mchk;
  endproperty
  a_push_rem: assert property (p_push_rem) else $error("remote push");
  property p_ignore;
    !lkstep_en [*3] ##0 dl == '0 |=> !da.mchk && !da.stall
      && da.inval_way == 4'h0 && da.lk_wr_way == 4'h0;
  endproperty
  a_ignore: assert property (p_ignore) else $error("lockstep off");
  property p_rst;
    disable iff (1'b0) rst |-> xsig_out == '0 && cache_act == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
endmodule
bind cpecs_top cpecs_chk i_cpecs_chk (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .lkstep_en, .cache_local, .xsig_in, .xsig_out, .cache_act);

// ==== tb/cpecs_partner.sv ====
// Behavioural partner core that drives the incoming cross-signals
`timescale 1ns/1ps
module cpecs_partner (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Command from the bench
  input wire logic send,
  input wire cpecs_pkg::cpecs_xin_t [1:0] pat,
  // Cross-signals toward the block
  output cpecs_pkg::cpecs_xin_t [1:0] xin
);
  // Idle way lines toggle: they mean nothing without the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      xin <= '0;
    end else if (send) begin
      xin <= pat;
    end else begin
      for (int c = 0; c < 2; c++) begin
        xin[c] <= {3'h0, ~xin[c].tagway, ~xin[c].drtway, ~xin[c].lkway};
      end
    end
  end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the cache error cross-signaling block
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic lkstep_en = 1'b0;
  logic send = 1'b0;
  cpecs_pkg::cpecs_local_t [1:0] cache_local = '0;
  cpecs_pkg::cpecs_xin_t [1:0] pat = '0;
  cpecs_pkg::cpecs_xin_t [1:0] xsig_in;
  cpecs_pkg::cpecs_xout_t [1:0] xsig_out;
  cpecs_pkg::cpecs_act_t [1:0] cache_act;
  cpecs_pkg::cpecs_local_t lv;
  int err_total = 0;
  int compares = 0;
  logic [31:0] q;
  cpecs_top i_cpecs_top (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .lkstep_en,
    .cache_local, .xsig_in, .xsig_out, .cache_act);
  cpecs_partner i_cpecs_partner (.ref_clk, .rst, .send, .pat,
    .xin(xsig_in));
  // Core clock
  always #5 ref_clk = ~ref_clk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Classic cycle held until ack is sampled; read data taken at that edge
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("[FAIL] %0t bus timeout", $time);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // One local event cycle; returns inside the answer cycle
  task loc(input int c, input cpecs_pkg::cpecs_local_t v);
    @(posedge ref_clk);
    cache_local[c] <= v;
    @(posedge ref_clk);
    cache_local[c] <= '0;
    #1;
  endtask
  // Partner event held len cycles; returns in the last answer cycle
  task rem(input int c, input cpecs_pkg::cpecs_xin_t v, input int len);
    @(posedge ref_clk);
    pat[c] <= v;
    send <= 1'b1;
    repeat (len) @(posedge ref_clk);
    send <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  // Watchdog sized well above the sequence length
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    $display("[FAIL] %0t watchdog", $time);
    end_of_test;
  end
  // Reset rises at time zero so the async clear lands before the first edge
  initial begin
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b1, 8'h04, 32'h1);
    wb(1'b0, 8'hfc, 32'h0);
    chk(q, 32'h0);
    lkstep_en <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h101);
    $display("test regs done");
    lv = '0;
    lv.tag_perr = 1'b1;
    lv.tag_unc_way = 4'h1;
    lv.tag_cor_way = 4'h2;
    lv.drt_way = 4'h3;
    lv.lk_way = 4'h4;
    lv.op_signal = 1'b1;
    lv.addr = 32'h12345678;
    for (int c = 0; c < 2; c++) begin
      loc(c, lv);
      chk(xsig_out[c].tagerr, 1);
      chk(xsig_out[c].tagway, 4'h1);
      chk(xsig_out[c].drtway, c ? 4'h0 : 4'h3);
      chk(xsig_out[c].addr, 32'h12345678);
      chk(cache_act[c].stall, 1);
      chk({cache_act[c].inval_way, cache_act[c].cor_way}, 8'h12);
      chk(cache_act[c].dirty_set_way, c ? 4'h0 : 4'h2);
      chk({cache_act[c].lk_wr_way, cache_act[c].lk_wr_data}, 8'h46);
    end
    wb(1'b0, 8'h18, 32'h0);
    chk(q, 32'h101);
    wb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h1);
    wb(1'b1, 8'h18, 32'hffff);
    wb(1'b0, 8'h18, 32'h0);
    chk(q, 32'h0);
    lv.op_signal = 1'b0;
    loc(0, lv);
    chk({xsig_out[0].tagerr, cache_act[0].stall}, 0);
    $display("test local tag done");
    lv = '0;
    lv.hit = 1'b1;
    lv.hit_way = 4'h2;
    lv.data_perr_way = 4'h2;
    lv.op_signal = 1'b1;
    lv.addr = 32'h0000abc0;
    loc(0, lv);
    chk(xsig_out[0].dataerr, 1);
    chk(xsig_out[0].addr, 32'h0000abc0);
    chk({cache_act[0].mchk, cache_act[0].reload_way}, 5'h02);
    lv.data_perr_way = 4'h1;
    loc(0, lv);
    chk(xsig_out[0].dataerr, 0);
    lv.data_perr_way = 4'h2;
    lv.tag_perr = 1'b1;
    loc(0, lv);
    chk(xsig_out[0].dataerr, 0);
    $display("test data done");
    wb(1'b1, 8'h00, 32'h0);
    lv = '0;
    lv.tag_perr = 1'b1;
    lv.tag_unc_way = 4'h1;
    lv.lk_way = 4'h4;
    lv.op_signal = 1'b1;
    loc(0, lv);
    chk({cache_act[0].mchk, cache_act[0].inval_way}, 5'h10);
    chk(cache_act[0].lk_wr_way, 4'h0);
    lv.cbi_op = 1'b1;
    loc(0, lv);
    chk({xsig_out[0].tagerr, cache_act[0].mchk}, 2'h2);
    lv = '0;
    lv.push_pend = 1'b1;
    lv.op_signal = 1'b1;
    loc(0, lv);
    chk({xsig_out[0].pusherr, cache_act[0].mchk}, 2'h3);
    rem(0, {3'b001, 12'h000}, 3);
    chk(cache_act[0].mchk, 1);
    $display("test machine check done");
    wb(1'b1, 8'h00, 32'h1);
    rem(0, {3'b100, 4'h1, 4'h3, 4'h8}, 1);
    chk({cache_act[0].stall, cache_act[0].inval_way}, 5'h11);
    chk(cache_act[0].dirty_set_way, 4'h2);
    chk(cache_act[0].lk_wr_way, 4'h8);
    @(posedge ref_clk);
    cache_local[0].hit_way <= 4'h4;
    rem(0, {3'b010, 12'h000}, 1);
    chk(cache_act[0].reload_way, 4'h4);
    @(posedge ref_clk);
    cache_local[0].hit_way <= 4'h0;
    $display("test partner done");
    lkstep_en <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rem(0, {3'b111, 4'h1, 4'h3, 4'h8}, 1);
    chk({cache_act[0].stall, cache_act[0].mchk}, 2'h0);
    chk(cache_act[0].inval_way, 4'h0);
    lv = '0;
    lv.tag_perr = 1'b1;
    lv.op_signal = 1'b1;
    loc(0, lv);
    chk(xsig_out[0].tagerr, 1);
    $display("test lockstep off done");
    @(posedge ref_clk);
    cache_local[0] <= lv;
    rst <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk({31'h0, |{xsig_out, cache_act}}, 32'h0);
    @(posedge ref_clk);
    rst <= 1'b0;
    cache_local[0] <= '0;
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    $display("test reset done");
    end_of_test;
  end
endmodule
